// ---- hdl/sfpi_top.sv ----
// serial flash pin interface: lane engine plus AHB-Lite register slave
// assumes hclk well above the serial clock; all pins arrive async
//
// Overview of operation
// - chip select high: all outputs high impedance
// - deselected: ignore data lanes and pause, stay in standby; guard and clear pins still act
// - chip select low selects, leaves standby
// - needs high-to-low select before first instruction
// - single lane: sample serial_in on rising clock
// - single lane: drive serial_out on falling clock
// - dual/quad: lanes bidirectional, same edges
// - quad uses write guard and pause pins
// - guard set and pin low blocks protection writes
// - guard clear: protection writes always allowed
// - quad enable disables write guard function
// - quad enable disables pause and clear functions
// - function select picks pause or hardware clear
// - pause keeps transfer progress, no restart
// - paused and selected: serial_out high impedance
// - pause release resumes where it stopped
// - hardware clear low: reset, outputs released
// - clock idle low or high both accepted
`timescale 1ns/1ps
`include "sfpi_regs.svh"

module sfpi_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        sclk,
    input  wire logic        chip_select_n,
    input  wire logic [3:0]  lane_in,
    output logic      [3:0]  lane_out,
    output logic      [3:0]  lane_oe
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    sfpi_pkg::sfpi_pins_s pin_meta;
    sfpi_pkg::sfpi_pins_s pin_sync;
    logic                 sclk_prev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // select reset low: arming needs a real high level
            pin_meta <= '{sclk: 1'b0, cs_n: 1'b0, lane: 4'hF};
            pin_sync <= '{sclk: 1'b0, cs_n: 1'b0, lane: 4'hF};
            sclk_prev <= 1'b0;
        end else begin
            pin_meta  <= '{sclk: sclk, cs_n: chip_select_n, lane: lane_in};
            pin_sync  <= pin_meta;
            sclk_prev <= pin_sync.sclk;
        end
    end

    // either idle level works: only edges inside a selection count
    logic sclk_rise;
    logic sclk_fall;
    assign sclk_rise = pin_sync.sclk & ~sclk_prev;
    assign sclk_fall = ~pin_sync.sclk & sclk_prev;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [1:0] width;
    logic       drive_out;
    logic       pin_function_select_bit;
    logic       status_write_disable_bit;
    logic       quad_io_enable_bit;
    logic [3:0] block_protect_bits;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic       rx_full;
    logic       tx_empty;

    // ------------------------------------------------------------------
    // shared pin functions
    // ------------------------------------------------------------------
    logic write_guard_pin_n;
    logic pause_pin_n;
    logic func_pause;
    logic func_clear;
    logic guard_active;
    logic clearing;
    logic paused;
    logic seen_high;
    logic selected;
    logic active;

    assign write_guard_pin_n = pin_sync.lane[2];
    assign pause_pin_n       = pin_sync.lane[3];
    assign func_pause = ~quad_io_enable_bit
                      & ~pin_function_select_bit;
    assign func_clear = ~quad_io_enable_bit
                      & pin_function_select_bit;
    // quad enable turns the guard pin into plain data
    assign guard_active = status_write_disable_bit & ~write_guard_pin_n
                        & ~quad_io_enable_bit;
    assign clearing = func_clear & ~pause_pin_n;
    assign paused   = func_pause & ~pause_pin_n
                    & ~pin_sync.cs_n;

    // select counts only after a high level has been seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_high <= 1'b0;
        end else if (clearing) begin
            seen_high <= 1'b0;
        end else if (pin_sync.cs_n) begin
            seen_high <= 1'b1;
        end
    end

    assign selected = ~pin_sync.cs_n & seen_high
                    & ~clearing;
    assign active   = selected & ~paused;

    sfpi_pkg::sfpi_link_e link_state;

    always_comb begin
        if (clearing) begin
            link_state = sfpi_pkg::LS_CLEAR;
        end else if (!selected) begin
            link_state = sfpi_pkg::LS_STANDBY;
        end else if (paused) begin
            link_state = sfpi_pkg::LS_PAUSED;
        end else begin
            link_state = sfpi_pkg::LS_ACTIVE;
        end
    end

    // quad without quad enable falls back to one lane
    logic [1:0] eff_width;
    always_comb begin
        if (width == `SFPI_WIDTH_QUAD && quad_io_enable_bit) begin
            eff_width = `SFPI_WIDTH_QUAD;
        end else if (width == `SFPI_WIDTH_DUAL) begin
            eff_width = `SFPI_WIDTH_DUAL;
        end else begin
            eff_width = `SFPI_WIDTH_SINGLE;
        end
    end

    // ------------------------------------------------------------------
    // receive path: rising serial clock
    // ------------------------------------------------------------------
    logic [7:0] rx_shift;
    logic [2:0] rx_cnt;
    logic [7:0] next_rx_shift;
    logic [2:0] next_rx_cnt;
    logic       rx_done;
    logic       rx_take;

    always_comb begin
        unique case (eff_width)
            `SFPI_WIDTH_DUAL: begin
                next_rx_shift = {rx_shift[5:0], pin_sync.lane[1:0]};
                next_rx_cnt   = rx_cnt + 3'h2;
            end
            `SFPI_WIDTH_QUAD: begin
                next_rx_shift = {rx_shift[3:0], pin_sync.lane};
                next_rx_cnt   = rx_cnt + 3'h4;
            end
            default: begin
                next_rx_shift = {rx_shift[6:0], pin_sync.lane[0]};
                next_rx_cnt   = rx_cnt + 3'h1;
            end
        endcase
    end

    assign rx_take = sclk_rise & active & ~drive_out;
    assign rx_done = rx_take && next_rx_cnt == 3'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_shift <= `SFPI_BYTE_RESET;
            rx_cnt   <= 3'h0;
        end else if (!selected) begin
            rx_shift <= `SFPI_BYTE_RESET;
            rx_cnt   <= 3'h0;
        end else if (rx_take) begin
            rx_shift <= next_rx_shift;
            rx_cnt   <= next_rx_cnt;
        end
    end

    // ------------------------------------------------------------------
    // transmit path: falling serial clock
    // ------------------------------------------------------------------
    logic [7:0] tx_shift;
    logic [2:0] tx_cnt;
    logic [3:0] out_bits;
    logic       out_valid;
    logic       tx_take;
    logic [3:0] next_out_bits;
    logic [7:0] next_tx_shift;
    logic [2:0] next_tx_cnt;

    always_comb begin
        next_out_bits = 4'h0;
        unique case (eff_width)
            `SFPI_WIDTH_DUAL: begin
                next_out_bits[1:0] = tx_shift[7:6];
                next_tx_shift      = {tx_shift[5:0], 2'b00};
                next_tx_cnt        = tx_cnt + 3'h2;
            end
            `SFPI_WIDTH_QUAD: begin
                next_out_bits = tx_shift[7:4];
                next_tx_shift = {tx_shift[3:0], 4'h0};
                next_tx_cnt   = tx_cnt + 3'h4;
            end
            default: begin
                next_out_bits[1] = tx_shift[7];
                next_tx_shift    = {tx_shift[6:0], 1'b0};
                next_tx_cnt      = tx_cnt + 3'h1;
            end
        endcase
    end

    assign tx_take = sclk_fall & active & drive_out;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_shift  <= `SFPI_BYTE_RESET;
            tx_cnt    <= 3'h0;
            out_bits  <= 4'h0;
            out_valid <= 1'b0;
        end else if (!selected) begin
            tx_shift  <= tx_data;
            tx_cnt    <= 3'h0;
            out_valid <= 1'b0;
        end else if (tx_take) begin
            out_bits  <= next_out_bits;
            out_valid <= 1'b1;
            tx_cnt    <= next_tx_cnt;
            tx_shift  <= (next_tx_cnt == 3'h0) ? tx_data : next_tx_shift;
        end
    end

    // ------------------------------------------------------------------
    // lane drivers
    // ------------------------------------------------------------------
    logic [3:0] lane_mask;
    always_comb begin
        unique case (eff_width)
            `SFPI_WIDTH_DUAL: lane_mask = 4'h3;
            `SFPI_WIDTH_QUAD: lane_mask = 4'hF;
            default:          lane_mask = 4'h2;
        endcase
    end

    // released when deselected, paused or cleared
    assign lane_oe  = (active & drive_out & out_valid)
                    ? lane_mask : 4'h0;
    assign lane_out = out_bits;

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    sfpi_pkg::sfpi_aphase_s aph;
    logic                   take_addr;
    logic [7:0]             a_ofs;
    logic                   wr_ctrl;
    logic                   wr_prot;
    logic                   wr_tx;
    logic                   rd_rx;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign take_addr = hsel & hready & htrans[1];
    assign a_ofs     = haddr[7:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00};
        end else if (hready) begin
            aph <= '{wr: take_addr & hwrite, rd: take_addr & ~hwrite,
                     addr: a_ofs};
        end
    end

    assign wr_ctrl = aph.wr && aph.addr == `SFPI_CTRL_OFS;
    assign wr_prot = aph.wr && aph.addr == `SFPI_PROT_OFS;
    assign wr_tx   = aph.wr && aph.addr == `SFPI_TXDATA_OFS;
    assign rd_rx   = take_addr && !hwrite && a_ofs == `SFPI_RXDATA_OFS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {pin_function_select_bit, drive_out, width} <= `SFPI_CTRL_RESET;
        end else if (wr_ctrl) begin
            width     <= hwdata[`SFPI_CTRL_WIDTH_MSB:`SFPI_CTRL_WIDTH_LSB];
            drive_out <= hwdata[`SFPI_CTRL_DRIVE_BIT];
            pin_function_select_bit <= hwdata[`SFPI_CTRL_FSEL_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {block_protect_bits, quad_io_enable_bit,
             status_write_disable_bit} <= `SFPI_PROT_RESET;
        end else if (wr_prot && !guard_active) begin
            status_write_disable_bit <= hwdata[`SFPI_PROT_STATUS_WRITE_DISABLE_BIT_BIT];
            quad_io_enable_bit       <= hwdata[`SFPI_PROT_QE_BIT];
            block_protect_bits <= hwdata[`SFPI_PROT_BP_MSB:`SFPI_PROT_BP_LSB];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_data <= `SFPI_BYTE_RESET;
        end else if (wr_tx) begin
            tx_data <= hwdata[7:0];
        end
    end

    // byte done wins over the clearing read or write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data  <= `SFPI_BYTE_RESET;
            rx_full  <= 1'b0;
            tx_empty <= 1'b1;
        end else begin
            if (rx_done) begin
                rx_data <= next_rx_shift;
                rx_full <= 1'b1;
            end else if (rd_rx) begin
                rx_full <= 1'b0;
            end
            if (tx_take && next_tx_cnt == 3'h0) begin
                tx_empty <= 1'b1;
            end else if (wr_tx) begin
                tx_empty <= 1'b0;
            end
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (a_ofs)
            `SFPI_CTRL_OFS: begin
                rd_mux[`SFPI_CTRL_WIDTH_MSB:`SFPI_CTRL_WIDTH_LSB] = width;
                rd_mux[`SFPI_CTRL_DRIVE_BIT] = drive_out;
                rd_mux[`SFPI_CTRL_FSEL_BIT]  = pin_function_select_bit;
            end
            `SFPI_PROT_OFS: begin
                rd_mux[`SFPI_PROT_STATUS_WRITE_DISABLE_BIT_BIT] = status_write_disable_bit;
                rd_mux[`SFPI_PROT_QE_BIT]   = quad_io_enable_bit;
                rd_mux[`SFPI_PROT_BP_MSB:`SFPI_PROT_BP_LSB] =
                    block_protect_bits;
            end
            `SFPI_TXDATA_OFS: rd_mux[7:0] = tx_data;
            `SFPI_RXDATA_OFS: rd_mux[7:0] = rx_data;
            `SFPI_STATUS_OFS: begin
                rd_mux[`SFPI_STAT_SEL_BIT] =
                    link_state != sfpi_pkg::LS_STANDBY
                    && link_state != sfpi_pkg::LS_CLEAR;
                rd_mux[`SFPI_STAT_PAUSE_BIT] =
                    link_state == sfpi_pkg::LS_PAUSED;
                rd_mux[`SFPI_STAT_CLEAR_BIT] =
                    link_state == sfpi_pkg::LS_CLEAR;
                rd_mux[`SFPI_STAT_RXFULL_BIT] = rx_full;
                rd_mux[`SFPI_STAT_TXEMPT_BIT] = tx_empty;
                rd_mux[`SFPI_STAT_GUARD_BIT]  = guard_active;
                rd_mux[`SFPI_STAT_STBY_BIT]   =
                    link_state == sfpi_pkg::LS_STANDBY;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take_addr && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

endmodule : sfpi_top

// ---- pkg/sfpi_regs.svh ----
// register offsets, field positions, reset values and codes of the
// serial flash pin interface; definitions only
`ifndef SFPI_REGS_SVH
`define SFPI_REGS_SVH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define SFPI_CTRL_OFS        8'h00
`define SFPI_PROT_OFS        8'h04
`define SFPI_TXDATA_OFS      8'h08
`define SFPI_RXDATA_OFS      8'h0C
`define SFPI_STATUS_OFS      8'h10

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define SFPI_CTRL_WIDTH_LSB  0
`define SFPI_CTRL_WIDTH_MSB  1
`define SFPI_CTRL_DRIVE_BIT  2
`define SFPI_CTRL_FSEL_BIT   3
`define SFPI_CTRL_RESET      4'h0

// ----------------------------------------------------------------------
// protection fields
// ----------------------------------------------------------------------
`define SFPI_PROT_STATUS_WRITE_DISABLE_BIT_BIT   0
`define SFPI_PROT_QE_BIT     1
`define SFPI_PROT_BP_LSB     2
`define SFPI_PROT_BP_MSB     5
`define SFPI_PROT_RESET      6'h00

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define SFPI_STAT_SEL_BIT    0
`define SFPI_STAT_PAUSE_BIT  1
`define SFPI_STAT_CLEAR_BIT  2
`define SFPI_STAT_RXFULL_BIT 3
`define SFPI_STAT_TXEMPT_BIT 4
`define SFPI_STAT_GUARD_BIT  5
`define SFPI_STAT_STBY_BIT   6

// ----------------------------------------------------------------------
// lane width codes
// ----------------------------------------------------------------------
`define SFPI_WIDTH_SINGLE    2'h0
`define SFPI_WIDTH_DUAL      2'h1
`define SFPI_WIDTH_QUAD      2'h2

`define SFPI_BYTE_RESET      8'h00

`endif

// ---- pkg/sfpi_pkg.sv ----
// types shared by the serial flash pin interface
// assumes sfpi_regs.svh for numeric constants
package sfpi_pkg;

    // link state as seen from the device pins
    typedef enum logic [1:0] {
        LS_STANDBY,
        LS_ACTIVE,
        LS_PAUSED,
        LS_CLEAR
    } sfpi_link_e;

    // synchronised pin levels
    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic [3:0] lane;
    } sfpi_pins_s;

    // captured AHB address phase
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
    } sfpi_aphase_s;

endpackage : sfpi_pkg

// ---- dv/sfpi_sva.sv ----
// checker on the ports of the serial flash pin interface top
// assumes a single hclk domain and hready tied to hreadyout
`timescale 1ns/1ps
`include "sfpi_regs.svh"

module sfpi_sva (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        sclk,
    input wire logic        chip_select_n,
    input wire logic [3:0]  lane_out,
    input wire logic [3:0]  lane_oe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    wire rd_req = hsel && hready && htrans[1] && !hwrite;

    sequence s_rd;
        rd_req;
    endsequence
    sequence s_desel;
        chip_select_n [*5];
    endsequence

    property p_ready;
        hreadyout && !hresp;
    endproperty
    property p_hold;
        !rd_req |=> $stable(hrdata);
    endproperty
    property p_unmapped;
        s_rd ##0 (haddr[7:0] > `SFPI_STATUS_OFS) |=> hrdata == 32'h0000_0000;
    endproperty
    property p_standby;
        s_desel ##0 s_rd ##0 (haddr[7:0] == `SFPI_STATUS_OFS)
            |=> hrdata[6] && !hrdata[0];
    endproperty
    property p_desel_hiz;
        s_desel |-> lane_oe == 4'h0;
    endproperty
    property p_oe_shape;
        lane_oe == 4'h0 || lane_oe == 4'h2
            || lane_oe == 4'h3 || lane_oe == 4'hf;
    endproperty
    property p_oe_rise;
        $rose(lane_oe != 4'h0) |-> !chip_select_n && !$past(sclk);
    endproperty
    property p_out_fall;
        $changed(lane_out) && lane_oe != 4'h0 |-> !$past(sclk);
    endproperty

    a_ready: assert property (p_ready)
        else $error("bus not ready or not okay");
    a_hold: assert property (p_hold)
        else $error("read data moved without a read");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_standby: assert property (p_standby)
        else $error("deselected but not in standby");
    a_desel_hiz: assert property (p_desel_hiz)
        else $error("lane driven while deselected");
    a_oe_shape: assert property (p_oe_shape)
        else $error("illegal lane drive pattern");
    a_oe_rise: assert property (p_oe_rise)
        else $error("drive started off a falling edge");
    a_out_fall: assert property (p_out_fall)
        else $error("output lane moved off a falling edge");
endmodule : sfpi_sva

bind sfpi_top sfpi_sva u_sfpi_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sclk(sclk),
    .chip_select_n(chip_select_n), .lane_out(lane_out), .lane_oe(lane_oe)
);

// ---- dv/sfpi_spi_master.sv ----
// behavioural spi bus master facing the flash pins
// assumes undriven lanes are pulled high by the bench
// tasks start on an hclk edge; pins move 1 ns after edges
`timescale 1ns/1ps

module sfpi_spi_master (
    output logic            sclk,
    output logic            chip_select_n,
    output logic [3:0]      m_val,
    output logic [3:0]      m_oe,
    input  wire logic [3:0] lane_in
);
    logic cpol;

    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b0;
        m_val = 4'h0;
        m_oe = 4'h0;
        cpol = 1'b0;
    end

    task automatic sel(input logic pol);
        #1;
        cpol = pol;
        sclk = pol;
        #4;
        chip_select_n = 1'b0;
        #20;
        #3;
    endtask : sel

    task automatic desel();
        #1;
        sclk = cpol;
        #16;
        chip_select_n = 1'b1;
        #40;
        #3;
    endtask : desel

    task automatic pin(input int i, input logic v, input logic en);
        #1;
        m_val[i] = v;
        m_oe[i] = en;
        #20;
        #3;
    endtask : pin

    // data set on the fall, taken by the device on the rise
    task automatic send(input logic [7:0] b, input int nb, input int k0,
                        input int k1);
        logic [3:0] msk;
        #1;
        msk = 4'((1 << nb) - 1);
        for (int k = k0; k < k1; k++) begin
            sclk = 1'b0;
            m_oe = m_oe | msk;
            m_val = (m_val & ~msk)
                  | (4'(b >> (8 - nb * (k + 1))) & msk);
            #16;
            sclk = 1'b1;
            #16;
        end
        m_oe = m_oe & ~msk;
        #3;
    endtask : send

    task automatic recv(inout logic [7:0] b, input int k0, input int k1);
        #1;
        for (int k = k0; k < k1; k++) begin
            sclk = 1'b1;
            #16;
            sclk = 1'b0;
            #16;
            b = {b[6:0], lane_in[1]};
        end
        #3;
    endtask : recv
endmodule : sfpi_spi_master

// ---- dv/tb_top.sv ----
// self-checking bench of the serial flash pin interface
// assumes sfpi_top, its checker bind and the spi master model
`timescale 1ns/1ps
`include "sfpi_regs.svh"

module tb_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        sclk;
    logic        chip_select_n;
    logic [3:0]  lane_in;
    logic [3:0]  lane_out;
    logic [3:0]  lane_oe;
    logic [3:0]  m_val;
    logic [3:0]  m_oe;
    logic [31:0] rd;
    logic [7:0]  b;
    logic [7:0]  tbl [3];
    int          bad_count;
    int          checks;

    // wire level: device, then master, else pull-up
    assign lane_in = (lane_oe & lane_out) | (~lane_oe & m_oe & m_val)
                   | (~lane_oe & ~m_oe);

    sfpi_top u_sfpi_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .sclk(sclk), .chip_select_n(chip_select_n),
        .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe)
    );
    sfpi_spi_master u_sfpi_spi_master (
        .sclk(sclk), .chip_select_n(chip_select_n), .m_val(m_val),
        .m_oe(m_oe), .lane_in(lane_in)
    );

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'h1;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask : ahb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        ahb(1'h0, a, 32'h0000_0000);
        chk(rd & m, exp);
    endtask : rd_chk

    task automatic t_select();
        rd_chk(`SFPI_CTRL_OFS, 32'hffff_ffff, 32'h0000_0000);
        rd_chk(`SFPI_PROT_OFS, 32'hffff_ffff, 32'h0000_0000);
        rd_chk(`SFPI_STATUS_OFS, 32'h0000_0018, 32'h0000_0010);
        ahb(1'h1, 8'h14, 32'hffff_ffff);
        rd_chk(8'h14, 32'hffff_ffff, 32'h0000_0000);
        u_sfpi_spi_master.send(8'ha5, 1, 0, 8);
        rd_chk(`SFPI_STATUS_OFS, 32'h0000_0008, 32'h0000_0000);
        u_sfpi_spi_master.desel();
        u_sfpi_spi_master.sel(1'h0);
        u_sfpi_spi_master.send(8'ha5, 1, 0, 8);
        u_sfpi_spi_master.desel();
        rd_chk(`SFPI_RXDATA_OFS, 32'h0000_00ff, 32'h0000_00a5);
        u_sfpi_spi_master.send(8'h3c, 1, 0, 8);
        rd_chk(`SFPI_STATUS_OFS, 32'h0000_0048, 32'h0000_0040);
    endtask : t_select

    task automatic t_widths();
        tbl = '{8'h96, 8'h69, 8'h5a};
        ahb(1'h1, `SFPI_PROT_OFS, 32'h0000_0002);
        for (int w = 0; w < 3; w++) begin
            ahb(1'h1, `SFPI_CTRL_OFS, 32'(w));
            u_sfpi_spi_master.sel(w == 1);
            u_sfpi_spi_master.send(tbl[w], 1 << w, 0, 8 >> w);
            u_sfpi_spi_master.desel();
            rd_chk(`SFPI_RXDATA_OFS, 32'h0000_00ff,
                   32'(tbl[w]));
            rd_chk(`SFPI_STATUS_OFS, 32'h0000_0008, 32'h0000_0000);
        end
        ahb(1'h1, `SFPI_PROT_OFS, 32'h0000_0000);
    endtask : t_widths

    task automatic t_guard();
        ahb(1'h1, `SFPI_PROT_OFS, 32'h0000_0001);
        u_sfpi_spi_master.pin(2, 1'h0, 1'h1);
        ahb(1'h1, `SFPI_PROT_OFS, 32'h0000_003d);
        rd_chk(`SFPI_PROT_OFS, 32'h0000_00ff, 32'h0000_0001);
        rd_chk(`SFPI_STATUS_OFS, 32'h0000_0020, 32'h0000_0020);
        u_sfpi_spi_master.pin(2, 1'h1, 1'h1);
        ahb(1'h1, `SFPI_PROT_OFS, 32'h0000_0003);
        rd_chk(`SFPI_PROT_OFS, 32'h0000_00ff, 32'h0000_0003);
        u_sfpi_spi_master.pin(2, 1'h0, 1'h1);
        ahb(1'h1, `SFPI_PROT_OFS, 32'h0000_0000);
        rd_chk(`SFPI_PROT_OFS, 32'h0000_00ff, 32'h0000_0000);
        ahb(1'h1, `SFPI_PROT_OFS, 32'h0000_003c);
        rd_chk(`SFPI_PROT_OFS, 32'h0000_00ff, 32'h0000_003c);
        ahb(1'h1, `SFPI_PROT_OFS, 32'h0000_0000);
        u_sfpi_spi_master.pin(2, 1'h1, 1'h0);
    endtask : t_guard

    task automatic t_pause();
        ahb(1'h1, `SFPI_TXDATA_OFS, 32'h0000_00c3);
        ahb(1'h1, `SFPI_CTRL_OFS, 32'h0000_0004);
        u_sfpi_spi_master.sel(1'h0);
        b = 8'h00;
        u_sfpi_spi_master.recv(b, 0, 4);
        chk(32'(lane_oe), 32'h0000_0002);
        u_sfpi_spi_master.pin(3, 1'h0, 1'h1);
        rd_chk(`SFPI_STATUS_OFS, 32'h0000_0003,
               32'h0000_0003);
        chk(32'(lane_oe), 32'h0000_0000);
        u_sfpi_spi_master.pin(3, 1'h1, 1'h0);
        u_sfpi_spi_master.recv(b, 4, 8);
        chk(32'(b), 32'h0000_00c3);
        rd_chk(`SFPI_STATUS_OFS, 32'h0000_0010, 32'h0000_0010);
        u_sfpi_spi_master.desel();
        ahb(1'h1, `SFPI_CTRL_OFS, 32'h0000_0000);
    endtask : t_pause

    task automatic t_clear();
        ahb(1'h1, `SFPI_CTRL_OFS, 32'h0000_0008);
        u_sfpi_spi_master.sel(1'h0);
        u_sfpi_spi_master.send(8'hff, 1, 0, 3);
        // three bits of a byte shifted in when the clear is pulled
        u_sfpi_spi_master.pin(3, 1'h0, 1'h1);
        rd_chk(`SFPI_STATUS_OFS, 32'h0000_0004, 32'h0000_0004);
        chk(32'(lane_oe), 32'h0000_0000);
        u_sfpi_spi_master.pin(3, 1'h1, 1'h0);
        u_sfpi_spi_master.desel();
        u_sfpi_spi_master.sel(1'h0);
        u_sfpi_spi_master.send(8'h81, 1, 0, 8);
        u_sfpi_spi_master.desel();
        rd_chk(`SFPI_RXDATA_OFS, 32'h0000_00ff, 32'h0000_0081);
        rd_chk(`SFPI_CTRL_OFS, 32'h0000_00ff, 32'h0000_0008);
        ahb(1'h1, `SFPI_CTRL_OFS, 32'h0000_0000);
    endtask : t_clear

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end

    initial begin
        bad_count = 0;
        checks = 0;
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        t_select();
        t_widths();
        t_guard();
        t_pause();
        t_clear();
        end_of_test();
    end
endmodule : tb_top
